// file: nfc_host.sv
// file: host controller for nand get/set features over axi4-lite
`timescale 1ns/100ps
module nfc_host
  import nfc_pkg::*;
#(
  parameter int PWRUP_CYCLES = PWRUP_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // nand pins
  output logic chip_enable_n,
  output logic cmd_latch,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic write_protect_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n
);
  nfc_state_type state_reg;
  nfc_op_type op_reg;
  logic [31:0] ctrl_reg;
  logic [7:0] faddr_reg;
  logic [31:0] wdata_reg;
  logic [31:0] rdata_reg;
  logic pwr_ok_reg, done_reg, go_pulse;
  logic [1:0] idx_reg;
  logic [3:0] ph_reg;
  logic t_start;
  logic [23:0] t_count;
  logic t_done;
  logic aw_hold, w_hold;
  logic [3:0] aw_addr;
  logic [31:0] w_data;

  // ------------------------------------------------------------
  // delay counter shared by power-up wait and the write-to-busy/read gap
  // ------------------------------------------------------------
  nfc_tick #(.WIDTH(24)) u_tick (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(t_start),
    .count(t_count),
    .done(t_done)
  );

  // ------------------------------------------------------------
  // axi4-lite write channel
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      ctrl_reg <= CTRL_RESET;
      faddr_reg <= FEAT_DRIVE;
      wdata_reg <= 32'h0;
      go_pulse <= 1'b0;
    end else begin
      go_pulse <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_hold <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_hold <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_hold && w_hold && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        case (aw_addr)
          REG_CTRL: begin
            ctrl_reg <= w_data;
            // go ignored while busy or before power-up wait ends
            go_pulse <= w_data[CTRL_GO] && state_reg == ST_IDLE;
          end
          REG_ADDR: faddr_reg <= w_data[7:0];
          REG_WDATA: wdata_reg <= w_data;
          REG_STAT: s_axi_bresp <= 2'b10;
          default: s_axi_bresp <= 2'b10;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // axi4-lite read channel
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        REG_CTRL: s_axi_rdata <= ctrl_reg;
        REG_ADDR: s_axi_rdata <= {24'h0, faddr_reg};
        REG_WDATA: s_axi_rdata <= rdata_reg;
        REG_STAT: s_axi_rdata <= {29'h0, done_reg, pwr_ok_reg,
                                  state_reg != ST_IDLE};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // nand sequencer
  // ------------------------------------------------------------
  always_comb begin
    t_start = 1'b0;
    t_count = 24'(PWRUP_CYCLES);
    if (state_reg == ST_PWRUP && !pwr_ok_reg && ph_reg == 4'd0) begin
      t_start = 1'b1;
    end else if (state_reg == ST_GAP && ph_reg == 4'd0) begin
      t_start = 1'b1;
      t_count = 24'(WHR_CYC);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= ST_PWRUP;
      op_reg <= OP_GET;
      pwr_ok_reg <= 1'b0;
      done_reg <= 1'b0;
      idx_reg <= 2'd0;
      ph_reg <= 4'd0;
      rdata_reg <= 32'h0;
      chip_enable_n <= 1'b1;
      cmd_latch <= 1'b0;
      addr_latch <= 1'b0;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      write_protect_n <= 1'b0; // held low through power-up
      io_out <= 8'h00;
      io_oe <= 1'b0;
    end else begin
      case (state_reg)
        ST_PWRUP: begin
          ph_reg <= 4'd1;
          if (t_done) begin
            pwr_ok_reg <= 1'b1; // 1ms before first command
            state_reg <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          chip_enable_n <= 1'b1;
          // protect level only changes between operations
          write_protect_n <= ctrl_reg[CTRL_WP];
          if (go_pulse) begin
            op_reg <= nfc_op_type'(ctrl_reg[CTRL_OP_LO +: 3]);
            done_reg <= 1'b0;
            chip_enable_n <= 1'b0;
            state_reg <= ST_CMD;
            ph_reg <= 4'd0;
          end
        end
        ST_CMD: begin
          cmd_latch <= 1'b1;
          io_oe <= 1'b1;
          case (op_reg)
            OP_GET: io_out <= CMD_GET_FEAT;
            OP_SET: io_out <= CMD_SET_FEAT;
            OP_STATUS: io_out <= CMD_STATUS;
            default: io_out <= CMD_RESET; // settings survive
          endcase
          ph_reg <= ph_reg + 4'd1;
          write_strobe_n <= ph_reg >= 4'(STROBE_CYC);
          if (ph_reg == 4'(2 * STROBE_CYC)) begin
            cmd_latch <= 1'b0;
            ph_reg <= 4'd0;
            idx_reg <= 2'd0;
            if (op_reg == OP_GET || op_reg == OP_SET) begin
              state_reg <= ST_ADDR;
            end else begin
              // reset too: busy may rise late after the strobe
              state_reg <= ST_GAP;
            end
          end
        end
        ST_ADDR: begin
          addr_latch <= 1'b1;
          io_out <= faddr_reg; // single address cycle
          ph_reg <= ph_reg + 4'd1;
          write_strobe_n <= ph_reg >= 4'(STROBE_CYC);
          if (ph_reg == 4'(2 * STROBE_CYC)) begin
            addr_latch <= 1'b0;
            ph_reg <= 4'd0;
            state_reg <= (op_reg == OP_SET) ? ST_WDATA : ST_GAP;
          end
        end
        ST_WDATA: begin
          // bytes PARAM_BYTES low byte first, one strobe each
          io_out <= wdata_reg[8*idx_reg +: 8];
          ph_reg <= ph_reg + 4'd1;
          write_strobe_n <= ph_reg >= 4'(STROBE_CYC);
          if (ph_reg == 4'(2 * STROBE_CYC)) begin
            ph_reg <= 4'd0;
            idx_reg <= idx_reg + 2'd1;
            if (idx_reg == 2'(PARAM_BYTES - 1)) begin
              io_oe <= 1'b0;
              state_reg <= ST_GAP; // busy follows fourth byte
            end
          end
        end
        ST_GAP: begin
          // covers write-to-busy and write-to-read delays
          io_oe <= 1'b0;
          ph_reg <= 4'd1;
          if (t_done) begin
            ph_reg <= 4'd0;
            state_reg <= (op_reg == OP_STATUS) ? ST_RDATA : ST_WAIT_RB;
          end
        end
        ST_WAIT_RB: begin
          // no command while busy; pin wait, not 70h polling
          if (ready_busy_n) begin
            if (op_reg == OP_GET) begin
              state_reg <= ST_RDATA;
            end else begin
              done_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_RDATA: begin
          // one byte per read strobe, after ready for get, straight after the gap for status
          ph_reg <= ph_reg + 4'd1;
          read_strobe_n <= ph_reg >= 4'(STROBE_CYC);
          if (ph_reg == 4'(STROBE_CYC)) begin
            rdata_reg[8*idx_reg +: 8] <= io_in;
          end
          if (ph_reg == 4'(2 * STROBE_CYC)) begin
            ph_reg <= 4'd0;
            idx_reg <= idx_reg + 2'd1;
            if (op_reg == OP_STATUS ||
                idx_reg == 2'(PARAM_BYTES - 1)) begin
              done_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

// file: nfc_pkg.sv
// package: constants for the nand feature host controller
package nfc_pkg;
  // nand command bytes, feature addresses and status fields
  localparam logic [7:0] CMD_GET_FEAT = 8'hEE;
  localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] FEAT_DRIVE = 8'h80;
  localparam logic [7:0] FEAT_RB_PULL = 8'h81;
  localparam int STATUS_READY_BIT = 5;
  localparam int DRV_FIELD_W = 2;
  // register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_WDATA = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hC;
  // ctrl register fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP_LO = 1;
  localparam int CTRL_WP = 4;
  // status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_PWR_OK = 1;
  localparam int STAT_DONE = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // timing, 200 MHz clock
  localparam int CLK_MHZ = 200;
  localparam int PWRUP_US = 1000;
  localparam int PWRUP_CYC = PWRUP_US * CLK_MHZ;
  localparam int FEAT_BUSY_US = 1;
  localparam int FEAT_BUSY_CYC = FEAT_BUSY_US * CLK_MHZ;
  localparam int STROBE_NS = 20;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int WHR_NS = 100;
  localparam int WHR_CYC = (WHR_NS * CLK_MHZ + 999) / 1000;
  localparam int PARAM_BYTES = 4;
  // host operations
  typedef enum logic [2:0] {
    OP_GET = 3'b000,
    OP_SET = 3'b001,
    OP_STATUS = 3'b010,
    OP_RESET = 3'b011
  } nfc_op_type;
  typedef enum logic [3:0] {
    ST_PWRUP = 4'b0000,
    ST_IDLE = 4'b0001,
    ST_CMD = 4'b0010,
    ST_ADDR = 4'b0011,
    ST_WDATA = 4'b0100,
    ST_WAIT_RB = 4'b0101,
    ST_RDATA = 4'b0110,
    ST_RECMD = 4'b0111,
    ST_GAP = 4'b1000
  } nfc_state_type;
endpackage

// file: nfc_tick.sv
// file: programmable delay counter giving a one-cycle done pulse
`timescale 1ns/100ps
module nfc_tick #(
  parameter int WIDTH = 24
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // control
  input wire logic start,
  input wire logic [WIDTH-1:0] count,
  output logic done
);
  logic [WIDTH-1:0] cnt_reg;
  logic run_reg;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_reg <= count;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (cnt_reg <= 1) begin
          run_reg <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 1'b1;
        end
      end
    end
  end
endmodule

// file: nfc_host_props.sv
// checker: protocol properties at the nand host ports
`timescale 1ns/100ps
module nfc_host_props
  import nfc_pkg::*;
#(
  parameter int PWRUP_CYCLES = PWRUP_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // axi read handshake
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // nand pins
  input wire logic chip_enable_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_protect_n,
  input wire logic io_oe,
  input wire logic ready_busy_n
);
  int up_cnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // saturates so long runs never wrap
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      up_cnt <= 0;
    end else if (up_cnt < PWRUP_CYCLES) begin
      up_cnt <= up_cnt + 1;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  pwrup_wait_a: assert property (
    cmd_latch |-> up_cnt >= PWRUP_CYCLES) else $error("early command");
  wp_low_a: assert property (
    up_cnt < PWRUP_CYCLES |-> !write_protect_n) else $error("wp high early");
  wp_steady_a: assert property (
    !chip_enable_n ##1 !chip_enable_n |-> $stable(write_protect_n))
    else $error("wp moved in operation");
  latch_sel_a: assert property (
    cmd_latch |-> !chip_enable_n && !addr_latch) else $error("bad latch");
  wr_pulse_a: assert property (
    $fell(write_strobe_n) |-> !write_strobe_n [*4] ##1 write_strobe_n)
    else $error("write strobe width");
  wr_drive_a: assert property (
    !write_strobe_n |-> io_oe && !chip_enable_n) else $error("io undriven");
  rd_ready_a: assert property (
    $fell(read_strobe_n) |-> ready_busy_n && !io_oe) else $error("read busy");
  cmd_idle_a: assert property (
    $rose(cmd_latch) |-> ready_busy_n) else $error("command while busy");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
  cmd_c: cover property ($rose(cmd_latch));
  addr_c: cover property ($rose(addr_latch));
  read_c: cover property ($fell(read_strobe_n));
endmodule

// file: nfc_nand_model.sv
// behavioural nand device for feature, status and reset commands
`timescale 1ns/100ps
module nfc_nand_model #(
  parameter int BUSY_NS = 600
) (
  // host strobes
  input wire logic chip_enable_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_protect_n,
  // data and busy
  input wire logic [7:0] io_out,
  output logic [7:0] io_in,
  output logic rb_low
);
  logic [31:0] feat [2] = '{32'h0, 32'h0};
  logic [31:0] pbuf = 32'h0;
  logic [7:0] cmd_reg = 8'h0, faddr = 8'h0, dout = 8'h0, last = 8'h0;
  int idx = 0;
  event go_busy;
  initial rb_low = 1'b0;
  // released bus shows the inverse, never a stale byte
  assign io_in = (!chip_enable_n && !read_strobe_n) ? dout : ~last;
  // busy edges land off the host clock edges to avoid sampling races
  always @(go_busy) begin
    #12 rb_low = 1'b1;
    #(BUSY_NS) rb_low = 1'b0;
  end
  // otp, program, erase and lock commands are not modelled
  always @(posedge write_strobe_n) if (!chip_enable_n) begin
    if (cmd_latch) begin
      cmd_reg = io_out;
      idx = 0;
      if (io_out == 8'hFF) -> go_busy;
    end else if (addr_latch) begin
      faddr = io_out;
      if (cmd_reg == 8'hEE) -> go_busy;
    end else if (cmd_reg == 8'hEF && idx < 4) begin
      pbuf[8*idx +: 8] = io_out;
      idx++;
      if (idx == 4) begin
        if (faddr[7:1] == 7'h40) feat[faddr[0]] = {30'h0, pbuf[1:0]};
        -> go_busy;
      end
    end
  end
  // status output stays until another command is latched
  // status bit 7 shows the protect level
  always @(negedge read_strobe_n) if (!chip_enable_n) begin
    if (cmd_reg == 8'h70) begin
      dout = {write_protect_n, {2{!rb_low}}, 5'h0};
    end else if (faddr[7:1] == 7'h40 && idx < 4) begin
      dout = feat[faddr[0]][8*idx +: 8];
    end else begin
      dout = 8'h0;
    end
  end
  always @(posedge read_strobe_n) begin
    last = dout;
    idx++;
  end
endmodule

// file: nfc_host_tb.sv
// self-checking testbench for the nand feature host controller
`timescale 1ns/100ps
module nfc_host_tb;
  import nfc_pkg::*;
  localparam int PWRUP_CYCLES = 50;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, chip_enable_n, cmd_latch, addr_latch, write_strobe_n;
  logic read_strobe_n, write_protect_n, io_oe, rb_low;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [7:0] io_out, io_in;
  wire ready_busy_n = ~rb_low;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  always #2.5 mclk = ~mclk;
  nfc_host #(.PWRUP_CYCLES(PWRUP_CYCLES)) dut_u (.mclk, .sys_rst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .chip_enable_n, .cmd_latch, .addr_latch,
    .write_strobe_n, .read_strobe_n, .write_protect_n, .io_out, .io_oe,
    .io_in, .ready_busy_n);
  nfc_nand_model nand_u (.chip_enable_n, .cmd_latch, .addr_latch,
    .write_strobe_n, .read_strobe_n, .write_protect_n, .io_out, .io_in,
    .rb_low);
  // ----------------------------------------
  // bus tasks and checks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic run_op(input logic [2:0] op, input logic wp);
    axi_wr(REG_CTRL, {27'h0, wp, op, 1'b1});
    for (int k = 0; k < 400; k++) begin
      axi_rd(REG_STAT);
      if (rd[STAT_DONE] === 1'b1) break;
    end
    chk("done", 32'h1, {31'h0, rd[STAT_DONE]});
  endtask
  task automatic feat_op(input logic [2:0] op, input logic [7:0] fa,
                         input logic [31:0] p);
    axi_wr(REG_ADDR, {24'h0, fa});
    if (op == OP_SET) axi_wr(REG_WDATA, p);
    run_op(op, 1'b1);
    axi_rd(REG_WDATA);
    if (op == OP_GET) chk("feature", p, rd);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    axi_rd(REG_STAT);
    chk("stat early", 32'h1, rd);
    axi_rd(REG_ADDR);
    chk("addr reset", 32'h80, rd);
    axi_rd(REG_CTRL);
    chk("ctrl reset", CTRL_RESET, rd);
    axi_rd(4'h2);
    chk("rd resp", 32'h2, {30'h0, rs});
    repeat (PWRUP_CYCLES) @(posedge mclk);
    axi_rd(REG_STAT);
    chk("stat ready", 32'h2, rd);
    axi_wr(REG_STAT, 32'hFFFF_FFFF);
    chk("ro resp", 32'h2, {30'h0, rs});
    $display("test registers done");
    feat_op(OP_GET, FEAT_RB_PULL, 32'h0);
    for (int c = 3; c >= 0; c--) begin
      feat_op(OP_SET, FEAT_DRIVE, c);
      feat_op(OP_GET, FEAT_DRIVE, c);
    end
    feat_op(OP_SET, FEAT_RB_PULL, 32'h2);
    $display("test features done");
    run_op(OP_RESET, 1'b1);
    feat_op(OP_GET, FEAT_RB_PULL, 32'h2);
    for (int w = 0; w < 2; w++) begin
      run_op(OP_STATUS, w[0]);
      axi_rd(REG_WDATA);
      chk("status", w ? 32'hE0 : 32'h60, {24'h0, rd[7:0]});
    end
    $display("test status done");
    complete_run();
  end
endmodule
bind nfc_host nfc_host_props #(.PWRUP_CYCLES(PWRUP_CYCLES)) props_u (.mclk,
  .sys_rst, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .chip_enable_n,
  .cmd_latch, .addr_latch, .write_strobe_n, .read_strobe_n, .write_protect_n,
  .io_oe, .ready_busy_n);
